// File: cfic_filter_ctrl.sv
// Capture channel and fault input glitch filters with their control registers.
// Assumes a classic Wishbone master on i_mclk and asynchronous input pins.
`timescale 1ns/1ns

module cfic_filter_ctrl (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [7:0] i_chan_in,
   input wire logic [3:0] i_fault_in,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   output logic [7:0] o_chan_level,
   output logic [3:0] o_fault_level,
   output logic [3:0] o_fault_flag,
   output logic o_irq
);

   logic [15:0] chan_filter;
   logic [11:0] fault_ctrl;
   logic [1:0] mode;
   logic [3:0] irq_en;
   logic [7:0] chan_meta;
   logic [7:0] chan_sync;
   logic [3:0] fault_meta;
   logic [3:0] fault_sync;
   logic [3:0] chan_cnt [4];
   logic [3:0] fault_cnt [4];
   logic [31:0] next_rd_data;
   logic [31:0] wmask;
   logic [3:0] next_flag;
   logic [3:0] next_irq_en;
   logic [3:0] fault_set;
   logic [3:0] fault_clr;
   logic wr_commit;
   logic wpd;
   logic [3:0] fault_val;

   // Address match on word index
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] base);
      return adr[7:2] == base[7:2];
   endfunction

   // Expand byte selects into a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // One filter step: returns new level and new sample count
   function automatic logic [4:0] filt_step(input logic raw, input logic filt,
      input logic [3:0] cnt, input logic [3:0] val);
      if (val == 4'h0 || raw == filt)
      begin
         return {raw, 4'h0};
      end
      else if (cnt == val - 4'h1)
      begin
         return {raw, 4'h0};
      end
      else
      begin
         return {filt, cnt + 4'h1};
      end
   endfunction

   assign wr_commit = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;
   assign wmask = lane_mask(i_wb_sel);
   assign wpd = mode[cfic_pkg::MODE_WPD_BIT];
   assign fault_val = fault_ctrl[cfic_pkg::FAULT_VAL_LSB +: cfic_pkg::FVAL_W];
   // Enable mask as it stands after this edge, so the interrupt never lags a write
   assign next_irq_en = (wr_commit && wmask[0] && hit(i_wb_adr, cfic_pkg::ADDR_IRQ_EN))
      ? i_wb_dat[3:0] : irq_en;

   // Bus acknowledge, one cycle after the request, dropped next cycle
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         o_wb_ack <= 1'b0;
      end
      else
      begin
         o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
      end
   end

   // Read data mux; unmapped addresses read zero
   always_comb
   begin
      next_rd_data = 32'h0000_0000;
      if (hit(i_wb_adr, cfic_pkg::ADDR_CHAN_FILTER))
      begin
         next_rd_data[15:0] = chan_filter;
      end
      else if (hit(i_wb_adr, cfic_pkg::ADDR_FAULT_CTRL))
      begin
         next_rd_data[11:0] = fault_ctrl;
      end
      else if (hit(i_wb_adr, cfic_pkg::ADDR_MODE))
      begin
         next_rd_data[1:0] = mode;
      end
      else if (hit(i_wb_adr, cfic_pkg::ADDR_STATUS))
      begin
         next_rd_data[3:0] = o_fault_flag;
      end
      else if (hit(i_wb_adr, cfic_pkg::ADDR_IRQ_EN))
      begin
         next_rd_data[3:0] = irq_en;
      end
   end

   // Read data register
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         o_wb_dat <= 32'h0000_0000;
      end
      else if (i_wb_cyc & i_wb_stb & ~o_wb_ack)
      begin
         o_wb_dat <= next_rd_data;
      end
   end

   // Channel filter register, no shadow copy
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         chan_filter <= cfic_pkg::CHAN_FILTER_RST;
      end
      else if (wr_commit && hit(i_wb_adr, cfic_pkg::ADDR_CHAN_FILTER))
      begin
         chan_filter <= (chan_filter & ~wmask[15:0]) | (i_wb_dat[15:0] & wmask[15:0]);
      end
   end

   // Fault control: value always writable, enables only when unprotected
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         fault_ctrl <= cfic_pkg::FAULT_CTRL_RST;
      end
      else if (wr_commit && hit(i_wb_adr, cfic_pkg::ADDR_FAULT_CTRL))
      begin
         fault_ctrl[11:8] <= (fault_ctrl[11:8] & ~wmask[11:8])
            | (i_wb_dat[11:8] & wmask[11:8]);
         if (wpd)
         begin
            fault_ctrl[7:0] <= (fault_ctrl[7:0] & ~wmask[7:0])
               | (i_wb_dat[7:0] & wmask[7:0]);
         end
      end
   end

   // Mode and interrupt enable registers
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         mode <= cfic_pkg::MODE_RST;
         irq_en <= cfic_pkg::IRQ_EN_RST;
      end
      else if (wr_commit && wmask[0])
      begin
         if (hit(i_wb_adr, cfic_pkg::ADDR_MODE))
         begin
            mode <= i_wb_dat[1:0];
         end
         if (hit(i_wb_adr, cfic_pkg::ADDR_IRQ_EN))
         begin
            irq_en <= i_wb_dat[3:0];
         end
      end
   end

   // Two-flop synchronisers on all pins
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         chan_meta <= 8'h00;
         chan_sync <= 8'h00;
         fault_meta <= 4'h0;
         fault_sync <= 4'h0;
      end
      else
      begin
         chan_meta <= i_chan_in;
         chan_sync <= chan_meta;
         fault_meta <= i_fault_in;
         fault_sync <= fault_meta;
      end
   end

   // Capture channel filters; upper channels pass straight through
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         o_chan_level <= 8'h00;
         for (int i = 0; i < cfic_pkg::N_FILT_CHAN; i++)
         begin
            chan_cnt[i] <= 4'h0;
         end
      end
      else
      begin
         for (int i = 0; i < cfic_pkg::N_FILT_CHAN; i++)
         begin
            {o_chan_level[i], chan_cnt[i]} <= filt_step(chan_sync[i], o_chan_level[i],
               chan_cnt[i], chan_filter[i*cfic_pkg::FVAL_W +: cfic_pkg::FVAL_W]);
         end
         o_chan_level[7:4] <= chan_sync[7:4];
      end
   end

   // Fault filters share one value; a per-input glitch enable, when clear, selects bypass
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         o_fault_level <= 4'h0;
         for (int i = 0; i < cfic_pkg::N_FAULT; i++)
         begin
            fault_cnt[i] <= 4'h0;
         end
      end
      else
      begin
         for (int i = 0; i < cfic_pkg::N_FAULT; i++)
         begin
            {o_fault_level[i], fault_cnt[i]} <= filt_step(fault_sync[i], o_fault_level[i],
               fault_cnt[i], fault_ctrl[cfic_pkg::GLITCH_EN_LSB + i] ? fault_val : 4'h0);
         end
      end
   end

   // Fault flags: set wins over a clear in the same cycle
   always_comb
   begin
      fault_set = o_fault_level & fault_ctrl[cfic_pkg::INPUT_EN_LSB +: 4]
         & {4{mode[cfic_pkg::MODE_FAULT_CTRL_BIT]}};
      fault_clr = 4'h0;
      if (wr_commit && wmask[0] && hit(i_wb_adr, cfic_pkg::ADDR_CLEAR))
      begin
         fault_clr = i_wb_dat[3:0];
      end
      next_flag = (o_fault_flag & ~fault_clr) | fault_set;
   end

   // Sticky status flags and level interrupt
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         o_fault_flag <= 4'h0;
         o_irq <= 1'b0;
      end
      else
      begin
         o_fault_flag <= next_flag;
         o_irq <= |(next_flag & next_irq_en);
      end
   end

   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);

   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held for more than one cycle");

   reserved_zero_a: assert property (
      (o_wb_ack && !i_wb_we && hit(i_wb_adr, cfic_pkg::ADDR_FAULT_CTRL)) |-> o_wb_dat[31:12] == 20'h0)
      else $error("fault control reserved bits read nonzero");

   protect_hold_a: assert property (
      (wr_commit && !wpd && hit(i_wb_adr, cfic_pkg::ADDR_FAULT_CTRL)) |=> $stable(fault_ctrl[7:0]))
      else $error("protected enable bits changed");

   protect_open_a: assert property (
      (wr_commit && wpd && wmask[0] && hit(i_wb_adr, cfic_pkg::ADDR_FAULT_CTRL))
      |=> fault_ctrl[7:0] == $past(i_wb_dat[7:0]))
      else $error("unprotected enable write lost");

   chan_write_a: assert property (
      (wr_commit && i_wb_sel[1:0] == 2'h3 && hit(i_wb_adr, cfic_pkg::ADDR_CHAN_FILTER))
      |=> chan_filter == $past(i_wb_dat[15:0]))
      else $error("channel filter write not immediate");

   upper_chan_a: assert property (o_chan_level[7:4] == $past(chan_sync[7:4]))
      else $error("upper channel not passed through");

   chan_bypass_a: assert property (
      (chan_filter[3:0] == 4'h0) |=> o_chan_level[0] == $past(chan_sync[0]))
      else $error("unfiltered channel 0 did not follow input");

   filter_hold_a: assert property (
      ($past(chan_filter[7:4]) != 4'h0 && $changed(o_chan_level[1]))
      |-> $past(chan_cnt[1]) == $past(chan_filter[7:4]) - 4'h1)
      else $error("channel 1 level changed before filter count");

   fault_bypass_a: assert property (
      (fault_val == 4'h0) |=> o_fault_level == $past(fault_sync))
      else $error("fault level filtered with zero value");

   flag_cause_a: assert property (
      $rose(o_fault_flag[0]) |-> $past(fault_set[0]))
      else $error("fault flag 0 set without cause");

   irq_level_a: assert property (o_irq == |(o_fault_flag & irq_en))
      else $error("interrupt does not match enabled flags");

endmodule

// File: cfic_pkg.sv
// Constants for the capture and fault input filter control block.
// Assumes a Wishbone slave with byte addresses in the low eight bits.
package cfic_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CHAN_FILTER = 8'h78;
   localparam logic [7:0] ADDR_FAULT_CTRL = 8'h7C;
   localparam logic [7:0] ADDR_MODE = 8'h80;
   localparam logic [7:0] ADDR_STATUS = 8'h84;
   localparam logic [7:0] ADDR_CLEAR = 8'h88;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h8C;
   // Field layout
   localparam int FVAL_W = 4;
   localparam int CHAN_FILTER_W = 16;
   localparam int FAULT_CTRL_W = 12;
   localparam int FAULT_VAL_LSB = 8;
   localparam int GLITCH_EN_LSB = 4;
   localparam int INPUT_EN_LSB = 0;
   localparam int MODE_FAULT_CTRL_BIT = 0;
   localparam int MODE_WPD_BIT = 1;
   localparam int N_FILT_CHAN = 4;
   localparam int N_CHAN = 8;
   localparam int N_FAULT = 4;
   // Reset values
   localparam logic [15:0] CHAN_FILTER_RST = 16'h0000;
   localparam logic [11:0] FAULT_CTRL_RST = 12'h000;
   localparam logic [1:0] MODE_RST = 2'h2;
   localparam logic [3:0] IRQ_EN_RST = 4'h0;
endpackage

// File: cfic_pin_model.sv
// Pin side model: raw capture channel and fault pins as the bench commands them.
// Assumes the bench changes its commands right after a rising edge of i_mclk.
`timescale 1ns/1ns
module cfic_pin_model (
   input wire logic i_mclk,
   input wire logic [11:0] i_pin_cmd,
   input wire logic [11:0] i_glitch,
   output logic [7:0] o_chan_in,
   output logic [3:0] o_fault_in
);
   // A glitch bit flips its pin for as long as the bench holds it
   always @(posedge i_mclk)
   begin
      o_chan_in <= i_pin_cmd[7:0] ^ i_glitch[7:0];
      o_fault_in <= i_pin_cmd[11:8] ^ i_glitch[11:8];
   end
endmodule

// File: testbench.sv
// Self-checking bench for the capture and fault input filter control block.
// Assumes one module clock of 25 MHz and a classic Wishbone register port.
`timescale 1ns/1ns
module testbench;
   logic mclk = 1'b0;
   logic rst_n, cyc, stb, we;
   logic [7:0] adr;
   logic [31:0] dat, rd, o_dat;
   logic [11:0] pin_cmd, glitch;
   logic [7:0] chan_in, chan_lvl;
   logic [3:0] fault_in, fault_lvl, flag, sel;
   logic ack, irq;
   logic [7:0] adrs [7] = '{8'h78, 8'h7C, 8'h80, 8'h84, 8'h88, 8'h8C, 8'h90};
   int num_errors, num_checks, m_filt, m_fctl, v;

   cfic_pin_model u_pins (.i_mclk(mclk), .i_pin_cmd(pin_cmd), .i_glitch(glitch),
      .o_chan_in(chan_in), .o_fault_in(fault_in));
   cfic_filter_ctrl u_dut (.i_mclk(mclk), .i_reset_n(rst_n), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
      .i_chan_in(chan_in), .i_fault_in(fault_in), .o_wb_dat(o_dat), .o_wb_ack(ack),
      .o_chan_level(chan_lvl), .o_fault_level(fault_lvl), .o_fault_flag(flag), .o_irq(irq));

   // Module clock
   always #20 mclk = ~mclk;

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= a;
      dat <= d;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         num_errors++;
         complete_run();
      end
      rd = o_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   // Flip one pin and count edges until its filtered level follows
   task automatic lat(input int idx, input int exp);
      int k;
      @(posedge mclk);
      pin_cmd[idx] <= ~pin_cmd[idx];
      k = 0;
      do
      begin
         @(posedge mclk);
         #1;
         k++;
      end
      while ((idx < 8 ? chan_lvl[idx] : fault_lvl[idx - 8]) !== pin_cmd[idx] && k < 30);
      chk(k, exp);
      if (k >= 30)
      begin
         complete_run();
      end
   endtask

   initial
   begin
      rst_n = 0;
      {cyc, stb, we, adr, dat, sel, pin_cmd, glitch} = '0;
      num_errors = 0;
      num_checks = 0;
      void'($urandom(32'hF1AC));
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      // Reset values, write-only clear and an unmapped place read zero
      foreach (adrs[i])
      begin
         wb(1'b0, adrs[i], 32'h0);
         chk(rd, adrs[i] == 8'h80 ? 32'(cfic_pkg::MODE_RST) : 32'h0);
      end
      $display("reset values done");
      // Random writes; reserved bits read back as zero
      repeat (4)
      begin
         m_filt = $urandom;
         m_fctl = $urandom;
         wb(1'b1, 8'h78, m_filt);
         wb(1'b1, 8'h7C, m_fctl);
         wb(1'b0, 8'h78, 32'h0);
         chk(rd, m_filt & 32'hFFFF);
         wb(1'b0, 8'h7C, 32'h0);
         chk(rd, m_fctl & 32'hFFF);
      end
      // Protection on: only the filter value field takes the write
      wb(1'b1, 8'h80, 32'h0);
      v = $urandom;
      wb(1'b1, 8'h7C, v);
      wb(1'b0, 8'h7C, 32'h0);
      chk(rd, (v & 32'hF00) | (m_fctl & 32'hFF));
      wb(1'b1, 8'h80, 32'h2);
      $display("register access done");
      // Capture filter latency per value; channel 4 never filtered
      foreach (adrs[i])
      begin
         v = (i * 5) % 16;
         wb(1'b1, 8'h78, 32'h1111 * v);
         lat(i % 4, v == 0 ? 4 : 3 + v);
         lat(4 + i % 4, 4);
      end
      // A one-cycle glitch is swallowed by a filter of four samples
      wb(1'b1, 8'h78, 32'h0040);
      @(posedge mclk);
      glitch <= 12'h002;
      @(posedge mclk);
      glitch <= 12'h000;
      repeat (10)
      begin
         @(posedge mclk);
         #1;
         chk(chan_lvl[1], pin_cmd[1]);
      end
      $display("capture filter done");
      // Fault 0 filtered by value 5, fault 1 enabled for nothing but its pin
      wb(1'b1, 8'h80, 32'h3);
      wb(1'b1, 8'h8C, 32'h1);
      wb(1'b1, 8'h7C, 32'h511);
      lat(8, 8);
      lat(9, 4);
      @(posedge mclk);
      #1;
      chk({irq, flag}, 5'h11);
      wb(1'b1, 8'h8C, 32'h0);
      repeat (2) @(posedge mclk);
      #1;
      chk(irq, 1'b0);
      lat(8, 8);
      lat(9, 4);
      wb(1'b1, 8'h88, 32'h1);
      wb(1'b0, 8'h84, 32'h0);
      chk(rd, 32'h0);
      // Zero filter value bypasses the enabled fault filter at once
      wb(1'b1, 8'h7C, 32'h011);
      lat(8, 4);
      lat(8, 4);
      wb(1'b0, 8'h84, 32'h0);
      chk(rd, 32'h1);
      wb(1'b1, 8'h88, 32'h1);
      // Fault control off: no flag for an enabled input
      wb(1'b1, 8'h80, 32'h2);
      lat(8, 4);
      repeat (2) @(posedge mclk);
      #1;
      chk(flag, 4'h0);
      $display("fault input done");
      complete_run();
   end
endmodule
